/* rtl/tcnt_pkg.sv */
// constants shared by the sixteen bit timer/counter
package tcnt_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // register map
  localparam logic [2:0] OFF_CONTROL = 3'h0;
  localparam logic [2:0] OFF_COUNT_LOW = 3'h1;
  localparam logic [2:0] OFF_COUNT_HIGH = 3'h2;
  localparam logic [2:0] OFF_IRQ_FLAGS = 3'h3;
  localparam logic [2:0] OFF_IRQ_ENABLE = 3'h4;
  // control field positions
  localparam int BIT_RUN = 0;
  localparam int BIT_SRC = 1;
  localparam int BIT_BYPASS = 2;
  localparam int BIT_OSC = 3;
  localparam int BIT_PSC_LO = 4;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_WIDE = 7;
  localparam logic [7:0] CONTROL_WMASK = 8'hbf;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int BIT_OVF = 0;
  // instruction cycle is one quarter of the core clock
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] PIN_ALL_INPUT = 2'h3;
  typedef enum logic [1:0] {
    TCNT_MODE_TIMER,
    TCNT_MODE_SYNC_COUNT,
    TCNT_MODE_ASYNC_COUNT
  } tcnt_mode_t;
endpackage : tcnt_pkg

/* rtl/tcnt_timer.sv */
// sixteen bit timer/counter with prescaler, wide access and overflow flag
// Functional notes
// - counting only while run bit 0 is set; value held otherwise
// - source bit 0: count once per instruction cycle, core clock over four
// - source bit 1: count rising edges of external pin or crystal
// - bypass bit 2 clear synchronises external clock, set counts it directly
// - bypass bit ignored while internal source selected
// - prescaler field 5:4 divides by 1, 2, 4 or 8
// - wide mode bit 7 gives one sixteen bit access, else two bytes
// - oscillator enable bit 3 turns crystal oscillator on or off
// - oscillator on forces both oscillator pins to inputs
// - wrap from all ones to zero raises overflow condition, except when a low or high byte count write (either mode) or a trigger falls in the same cycle
// - compare unit trigger clears the count
// - three modes: timer, synchronous counter, asynchronous counter
// - control bit 6 reads zero, writes ignored
// - count held as readable, writable low and high bytes
// - crystal oscillator keeps running during sleep
// - wide mode: low read copies live high byte into buffer
// - wide mode: high writes buffer only; low write loads buffer and written byte into count
// - overflow sets latched flag bit 0; interrupt output gated by enable bit
// - software write beats trigger; trigger never sets overflow flag
module tcnt_timer
  import tcnt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_ext_clk_pin,
  input wire logic i_crystal_clk,
  input wire logic i_special_event,
  input wire logic i_sleep,
  input wire logic [1:0] i_port_c_dir,
  output logic [1:0] o_pin_dir,
  output logic o_crystal_osc_on,
  output logic o_overflow_flag,
  output logic o_overflow_irq,
  output tcnt_mode_t o_mode
);

  logic [7:0] timer_control;
  logic [15:0] count;
  logic [7:0] count_high_buffer;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [1:0] instr_div;
  logic instr_tick;
  logic [1:0] rise;
  logic ext_rise;
  logic ext_pend;
  logic src_event;
  logic [2:0] psc_cnt;
  logic [2:0] psc_max;
  logic inc;
  logic wrap_d;
  logic wr_low, wr_high, rd_low;
  logic run, src_ext, bypass, osc_en, wide;
  logic [1:0] psel;

  assign run = timer_control[BIT_RUN];
  assign src_ext = timer_control[BIT_SRC];
  assign bypass = timer_control[BIT_BYPASS];
  assign osc_en = timer_control[BIT_OSC];
  assign psel = timer_control[BIT_PSC_LO+1:BIT_PSC_LO];
  assign wide = timer_control[BIT_WIDE];
  assign wr_low = i_wr && (i_addr == OFF_COUNT_LOW);
  assign wr_high = i_wr && (i_addr == OFF_COUNT_HIGH);
  assign rd_low = i_rd && (i_addr == OFF_COUNT_LOW);

  // control register; bit 6 has no storage
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      timer_control <= CONTROL_RESET;
    end else if (i_wr && i_addr == OFF_CONTROL) begin
      timer_control <= i_wdata & CONTROL_WMASK;
    end
  end

  // instruction cycle enable; halted while asleep
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      instr_div <= 2'h0;
    end else if (instr_div == INSTR_LAST) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end
  assign instr_tick = (instr_div == INSTR_LAST) && !i_sleep;

  // pin and crystal inputs, three stages each; a change counts once the
  // second and third stages agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      logic stage1, stage2, stage3, settled;
      always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
          settled <= 1'b0;
        end else begin
          stage1 <= (g == 0) ? i_ext_clk_pin : i_crystal_clk;
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            settled <= stage2;
          end
        end
      end
      assign rise[g] = (stage2 == stage3) && stage2 && !settled;
    end
  endgenerate
  assign ext_rise = osc_en ? rise[1] : rise[0];

  // synchronous counting waits for the next instruction cycle; sleep
  // therefore stops it, while the direct path keeps counting
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ext_pend <= 1'b0;
    end else if (!src_ext || bypass) begin
      ext_pend <= 1'b0;
    end else if (ext_rise) begin
      ext_pend <= 1'b1;
    end else if (instr_tick) begin
      ext_pend <= 1'b0;
    end
  end

  always_comb begin
    if (!src_ext) begin
      src_event = instr_tick;
    end else if (bypass) begin
      src_event = ext_rise;
    end else begin
      src_event = ext_pend && instr_tick;
    end
  end

  always_comb begin
    case (psel)
      2'h0: psc_max = 3'h0;
      2'h1: psc_max = 3'h1;
      2'h2: psc_max = 3'h3;
      2'h3: psc_max = 3'h7;
      default: psc_max = 3'h0;
    endcase
  end

  // prescaler; cleared by a low byte write, never by a high byte write
  always_ff @(posedge i_core_clk) begin
    if (i_reset || wr_low) begin
      psc_cnt <= 3'h0;
    end else if (run && src_event) begin
      psc_cnt <= (psc_cnt >= psc_max) ? 3'h0 : psc_cnt + 3'h1;
    end
  end
  assign inc = run && src_event && (psc_cnt >= psc_max);

  // live count; a software write beats the trigger
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count <= COUNT_RESET;
    end else if (wr_low) begin
      if (wide) begin
        count <= {count_high_buffer, i_wdata};
      end else begin
        count[7:0] <= i_wdata;
      end
    end else if (wr_high && !wide) begin
      count[15:8] <= i_wdata;
    end else if (i_special_event) begin
      count <= COUNT_RESET;
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  // high byte buffer for wide access
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count_high_buffer <= 8'h00;
    end else if (wide && wr_high) begin
      count_high_buffer <= i_wdata;
    end else if (wide && rd_low) begin
      count_high_buffer <= count[15:8];
    end
  end

  // wrap marker: only a real increment counts, so a trigger never sets it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wrap_d <= 1'b0;
    end else begin
      wrap_d <= inc && (count == COUNT_MAX) && !wr_low && !wr_high
        && !i_special_event;
    end
  end

  // overflow flag: a new wrap wins over a clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      overflow_flag <= 1'b0;
    end else if (wrap_d) begin
      overflow_flag <= 1'b1;
    end else if (i_wr && i_addr == OFF_IRQ_FLAGS) begin
      overflow_flag <= i_wdata[BIT_OVF];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      overflow_irq_enable <= 1'b0;
    end else if (i_wr && i_addr == OFF_IRQ_ENABLE) begin
      overflow_irq_enable <= i_wdata[BIT_OVF];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      case (i_addr)
        OFF_CONTROL: o_rdata <= timer_control;
        OFF_COUNT_LOW: o_rdata <= count[7:0];
        OFF_COUNT_HIGH: o_rdata <= wide ? count_high_buffer : count[15:8];
        OFF_IRQ_FLAGS: o_rdata <= {7'h00, overflow_flag};
        OFF_IRQ_ENABLE: o_rdata <= {7'h00, overflow_irq_enable};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // oscillator enable does not depend on sleep
  assign o_crystal_osc_on = osc_en;
  assign o_pin_dir = osc_en ? PIN_ALL_INPUT : i_port_c_dir;
  assign o_overflow_flag = overflow_flag;
  assign o_overflow_irq = overflow_flag && overflow_irq_enable;

  always_comb begin
    if (!src_ext) begin
      o_mode = TCNT_MODE_TIMER;
    end else if (bypass) begin
      o_mode = TCNT_MODE_ASYNC_COUNT;
    end else begin
      o_mode = TCNT_MODE_SYNC_COUNT;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  logic quiet;
  assign quiet = !i_wr && !i_special_event;

  sequence s_wrap;
    inc && count == COUNT_MAX && quiet;
  endsequence

  sequence s_zero_then_flag;
    count == COUNT_RESET ##1 overflow_flag;
  endsequence

  stop_holds_a: assert property (!run && quiet |=> $stable(count))
    else $error("count moved while stopped");
  internal_rate_a: assert property (!src_ext && inc |-> instr_tick)
    else $error("internal count off instruction cycle");
  ext_direct_a: assert property (run && src_ext && bypass && ext_rise
    && psel == 2'h0 && quiet |=> count == $past(count) + 16'h0001)
    else $error("direct external edge not counted");
  ext_sync_a: assert property (src_ext && !bypass && inc |-> instr_tick)
    else $error("synchronous count off instruction cycle");
  prescale_eight_a: assert property (psel == 2'h3 && inc
    |=> !inc [*7])
    else $error("prescale by eight too fast");
  wide_read_a: assert property (wide && rd_low && !i_wr
    |=> count_high_buffer == $past(count[15:8]))
    else $error("high byte not buffered");
  wide_write_a: assert property (wide && wr_low
    |=> count == {$past(count_high_buffer), $past(i_wdata)})
    else $error("wide write not applied");
  unused_bit_a: assert property (i_rd && i_addr == OFF_CONTROL
    |=> o_rdata[BIT_UNUSED] == 1'b0)
    else $error("control bit 6 not zero");
  pins_input_a: assert property (osc_en |-> o_pin_dir == PIN_ALL_INPUT)
    else $error("oscillator pins not inputs");
  trigger_clear_a: assert property (i_special_event && !i_wr
    |=> count == COUNT_RESET)
    else $error("trigger did not clear count");
  write_wins_a: assert property (wr_low && !wide && i_special_event
    |=> count[7:0] == $past(i_wdata))
    else $error("trigger beat write");
  wrap_flag_a: assert property (s_wrap |=> s_zero_then_flag)
    else $error("wrap did not set flag");

endmodule : tcnt_timer

/* bench/tcnt_ext_src.sv */
// far-side clock source: external clock pin and crystal oscillator output
module tcnt_ext_src (
  output logic o_pin,
  output logic o_xtal
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_pin = 1'b0;
    o_xtal = 1'b0;
  end
  // both lines rest low between bursts; no free-running clock
  // 170 ns half period keeps rising edges out of phase with the core clock; every falling edge lands on a core clock edge, every second one on a rising edge
  task automatic burst(input bit xtal, input int n);
    repeat (n) begin
      #170;
      if (xtal) begin
        o_xtal = 1'b1;
      end else begin
        o_pin = 1'b1;
      end
      #170;
      o_pin = 1'b0;
      o_xtal = 1'b0;
    end
  endtask : burst
endmodule : tcnt_ext_src

/* bench/tb_sixteen_bit_timer_counter.sv */
// self-checking bench for the sixteen bit timer/counter
module tb_sixteen_bit_timer_counter
  import tcnt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_special_event = 1'b0;
  logic i_sleep = 1'b0;
  logic [1:0] i_port_c_dir = 2'h1;
  logic [7:0] o_rdata, ctl;
  logic ext_pin, xtal, o_crystal_osc_on, o_overflow_flag, o_overflow_irq;
  logic [1:0] o_pin_dir, p;
  logic [15:0] s;
  tcnt_mode_t o_mode;
  int num_errors = 0;
  int n_tests = 0;
  int edge_no = 0;
  int m, t0, we, n, cyc;
  // bits: crystal, bypass, sleep
  bit [2:0] ext_cfg [4] = '{3'b000, 3'b010, 3'b111, 3'b100};

  tcnt_ext_src src (.o_pin(ext_pin), .o_xtal(xtal));
  tcnt_timer dut (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ext_clk_pin(ext_pin), .i_crystal_clk(xtal),
    .i_special_event(i_special_event), .i_sleep(i_sleep),
    .i_port_c_dir(i_port_c_dir), .o_pin_dir(o_pin_dir),
    .o_crystal_osc_on(o_crystal_osc_on), .o_overflow_flag(o_overflow_flag),
    .o_overflow_irq(o_overflow_irq), .o_mode(o_mode));

  always #20 i_core_clk = ~i_core_clk;
  // edge index since reset release; instruction ticks land on multiples of 4
  always @(posedge i_core_clk) edge_no <= i_reset ? 0 : edge_no + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one gap edge after each strobe so no signal is driven twice at an edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1 we = edge_no;
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_core_clk);
  endtask : rd

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(16'(v), 16'(e));
  endtask : rdchk

  task automatic rdcnt(input logic [15:0] e);
    logic [7:0] lo, hi;
    rd(OFF_COUNT_LOW, lo);
    rd(OFF_COUNT_HIGH, hi);
    check({hi, lo}, e);
  endtask : rdcnt

  task automatic pulse_trigger;
    i_special_event <= 1'b1;
    @(posedge i_core_clk);
    i_special_event <= 1'b0;
    @(posedge i_core_clk);
  endtask : pulse_trigger

  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  initial begin
    #3000000;
    num_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h2e01));
    repeat (3) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    for (int k = 0; k < 8; k++) rdchk(3'(k), 8'h00);
    check(16'(o_pin_dir), 16'(i_port_c_dir));
    wr(OFF_CONTROL, 8'hff);
    check(16'(o_pin_dir), 16'(PIN_ALL_INPUT));
    rdchk(OFF_CONTROL, 8'hbf);
    wr(OFF_CONTROL, 8'h00);
    wr(3'h7, 8'hff);
    rdchk(3'h7, 8'h00);
    for (int i = 0; i < 8; i++) begin
      // odd runs start near the top; runs 1 and 5, prescaled by two, are sure to wrap
      s = (i % 2) ? 16'hffff - 16'($urandom % 4) : 16'($urandom);
      cyc = 40 + $urandom % 300;
      ctl = {2'b00, 2'(i % 4), 1'b0, 1'(i / 4), 2'b00};
      wr(OFF_IRQ_ENABLE, 8'(i > 4));
      wr(OFF_IRQ_FLAGS, 8'h00);
      wr(OFF_CONTROL, ctl);
      wr(OFF_COUNT_HIGH, s[15:8]);
      wr(OFF_COUNT_LOW, s[7:0]);
      wr(OFF_CONTROL, ctl | 8'h01);
      t0 = we;
      repeat (cyc) @(posedge i_core_clk);
      wr(OFF_CONTROL, ctl);
      m = s + (we / 4 - t0 / 4) / (1 << (i % 4));
      check(16'(o_mode), 16'(TCNT_MODE_TIMER));
      rdcnt(16'(m));
      check(16'(o_overflow_flag), 16'(m > 65535));
      check(16'(o_overflow_irq), 16'(m > 65535 && i > 4));
    end
    wr(OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_COUNT_HIGH, 8'hff);
    wr(OFF_COUNT_LOW, 8'hff);
    pulse_trigger();
    rdcnt(16'h0000);
    rdchk(OFF_IRQ_FLAGS, 8'h00);
    fork
      wr(OFF_COUNT_LOW, 8'h5a);
      pulse_trigger();
    join
    rdcnt(16'h005a);
    wr(OFF_CONTROL, 8'h80);
    wr(OFF_COUNT_HIGH, 8'h12);
    rdchk(OFF_COUNT_HIGH, 8'h12);
    wr(OFF_COUNT_LOW, 8'h34);
    wr(OFF_COUNT_HIGH, 8'h56);
    rdcnt(16'h1234);
    wr(OFF_CONTROL, 8'h00);
    rdcnt(16'h1234);
    foreach (ext_cfg[j]) begin
      n = 8 + $urandom % 17;
      // direct pin run without prescaler exercises the single-edge check
      p = (j == 1) ? 2'h0 : 2'($urandom);
      i_port_c_dir <= 2'($urandom);
      ctl = {2'b00, p, ext_cfg[j][2:1], 2'b10};
      wr(OFF_CONTROL, ctl);
      check(16'(o_crystal_osc_on), 16'(ext_cfg[j][2]));
      check(16'(o_pin_dir),
        16'(ext_cfg[j][2] ? PIN_ALL_INPUT : i_port_c_dir));
      check(16'(o_mode), ext_cfg[j][1] ? 16'(TCNT_MODE_ASYNC_COUNT)
        : 16'(TCNT_MODE_SYNC_COUNT));
      wr(OFF_COUNT_HIGH, 8'h00);
      wr(OFF_COUNT_LOW, 8'h00);
      // oscillator start-up allowance before relying on it
      repeat (40) @(posedge i_core_clk);
      wr(OFF_CONTROL, ctl | 8'h01);
      i_sleep <= ext_cfg[j][0];
      src.burst(ext_cfg[j][2], n);
      repeat (12) @(posedge i_core_clk);
      check(16'(o_crystal_osc_on), 16'(ext_cfg[j][2]));
      i_sleep <= 1'b0;
      wr(OFF_CONTROL, ctl);
      rdcnt(16'(n / (1 << p)));
    end
    test_done();
  end
endmodule : tb_sixteen_bit_timer_counter
